// *** src/aer_error_log_pkg.sv ***
// Package with offsets, field masks and reset values of the error log registers
package aer_error_log_pkg;
  localparam logic [11:0] UNC_STATUS_OFF = 12'h104;
  localparam logic [11:0] UNC_MASK_OFF = 12'h108;
  localparam logic [11:0] UNC_SEV_OFF = 12'h10C;
  localparam logic [11:0] COR_STATUS_OFF = 12'h110;
  localparam logic [11:0] COR_MASK_OFF = 12'h114;
  localparam logic [11:0] CAP_CTRL_OFF = 12'h118;
  localparam logic [11:0] HDR_LOG0_OFF = 12'h11C;
  localparam logic [11:0] HDR_LOG1_OFF = 12'h120;
  localparam logic [11:0] HDR_LOG2_OFF = 12'h124;
  localparam logic [11:0] HDR_LOG3_OFF = 12'h128;
  localparam logic [11:0] SEC_STATUS_OFF = 12'h12C;
  localparam logic [11:0] SEC_MASK_OFF = 12'h130;
  localparam logic [11:0] SEC_SEV_OFF = 12'h134;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h200;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h204;
  localparam logic [31:0] UNC_BITS = 32'h001FF011;
  localparam logic [31:0] UNC_SEV_RESET = 32'h00062011;
  localparam logic [31:0] COR_BITS = 32'h000011C1;
  localparam logic [31:0] SEC_BITS = 32'h00003FEF;
  localparam logic [31:0] SEC_MASK_RESET = 32'h000017A8;
  localparam logic [31:0] SEC_SEV_RESET = 32'h00001340;
  localparam int FEP_LSB = 0;
  localparam int ECRC_GEN_CAP_BIT = 5;
  localparam int ECRC_GEN_EN_BIT = 6;
  localparam int ECRC_CHK_CAP_BIT = 7;
  localparam int ECRC_CHK_EN_BIT = 8;
  localparam int IRQ_COR = 0;
  localparam int IRQ_NONFATAL = 1;
  localparam int IRQ_FATAL = 2;
  localparam logic [2:0] IRQ_BITS = 3'h7;
endpackage

// *** src/aer_error_log_regs.sv ***
// Error reporting register bank with classic Wishbone slave
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Uncorrectable severity is sticky read-write, bits 0,4,13,17,18 reset to one.
// - Severity bit positions follow the primary error layout, bits 31:21 read zero.
// - Correctable status bits 0,6,7,8,12 are sticky write-one-to-clear, reset zero.
// - Correctable mask holds sticky read-write bits at the status positions, reset zero.
// - A five-bit sticky read-only first error pointer sits in bits 4:0 of control.
// - ECRC capable bits 5 and 7 read one; enables at bits 6 and 8 reset zero.
// - Four sticky read-only header words hold byte 0 of each word in bits 31:24.
// - Secondary status bits 0-3 and 5-9 are sticky write-one-to-clear, reset zero.
// - Secondary status also holds bits 10 to 13; bit 4 and 31:14 are reserved.
// - Secondary mask is sticky read-write, bits 3,5,7,8,9,10,12 reset to one.
// - Secondary severity is sticky read-write, bits 6,8,9,12 reset to one.
// - Primary uncorrectable status is sticky write-one-to-clear at severity positions.
// - Primary uncorrectable mask is sticky read-write at severity positions, reset zero.
module aer_error_log_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] unc_err_i,
  input wire logic [31:0] cor_err_i,
  input wire logic [31:0] sec_err_i,
  input wire logic [127:0] err_header_i,
  output logic ecrc_gen_en_o,
  output logic ecrc_chk_en_o,
  output logic err_fatal_o,
  output logic err_nonfatal_o,
  output logic err_cor_o,
  output logic irq_o
);
  logic [31:0] unc_status_q, unc_mask_q, unc_sev_q;
  logic [31:0] cor_status_q, cor_mask_q;
  logic [31:0] sec_status_q, sec_mask_q, sec_sev_q;
  logic [4:0] fep_q;
  logic gen_en_q, chk_en_q;
  logic [31:0] hdr_q [4];
  logic [2:0] irq_status_q, irq_mask_q;
  logic [31:0] wmask, rdata;
  logic wr_en, req;
  logic [31:0] unc_new, sec_new;
  logic [4:0] fep_idx;
  logic log_unc, log_sec, fatal_ev, nonfatal_ev, cor_ev;
  logic [2:0] irq_ev;

  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Write-one-to-clear with set winning over clear
  function automatic logic [31:0] w1c(input logic [31:0] cur, input logic [31:0] set,
                                      input logic [31:0] clr, input logic [31:0] bits);
    w1c = ((cur & ~clr) | set) & bits;
  endfunction

  // Read-write merge under byte lanes
  function automatic logic [31:0] rw(input logic [31:0] cur, input logic [31:0] d,
                                     input logic [31:0] m, input logic [31:0] bits);
    rw = ((cur & ~m) | (d & m)) & bits;
  endfunction

  function automatic logic [4:0] lowest(input logic [31:0] v);
    lowest = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        lowest = 5'(i);
      end
    end
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = req && wb_we_i;
  assign wmask = sel_mask(wb_sel_i);

  // Only unmasked new errors capture pointer and header and raise reports; status logs all
  assign unc_new = unc_err_i & package_unc_bits() & ~unc_mask_q;
  assign sec_new = sec_err_i & aer_error_log_pkg::SEC_BITS & ~sec_mask_q;
  assign log_unc = |unc_new;
  assign log_sec = |sec_new;
  assign fep_idx = lowest(unc_new);
  assign fatal_ev = |(unc_new & unc_sev_q) || |(sec_new & sec_sev_q);
  assign nonfatal_ev = |(unc_new & ~unc_sev_q) || |(sec_new & ~sec_sev_q);
  assign cor_ev = |(cor_err_i & aer_error_log_pkg::COR_BITS & ~cor_mask_q);
  assign irq_ev = {fatal_ev, nonfatal_ev, cor_ev};

  function automatic logic [31:0] package_unc_bits();
    package_unc_bits = aer_error_log_pkg::UNC_BITS;
  endfunction

  // Sticky fields use power-on reset only; link reset is ignored here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unc_status_q <= 32'h00000000;
      unc_mask_q <= 32'h00000000;
      unc_sev_q <= aer_error_log_pkg::UNC_SEV_RESET;
    end else begin
      unc_status_q <= w1c(unc_status_q, unc_err_i & aer_error_log_pkg::UNC_BITS,
        (wr_en && wb_adr_i == aer_error_log_pkg::UNC_STATUS_OFF) ? wb_dat_i & wmask
        : 32'h00000000, aer_error_log_pkg::UNC_BITS);
      if (wr_en && wb_adr_i == aer_error_log_pkg::UNC_MASK_OFF) begin
        unc_mask_q <= rw(unc_mask_q, wb_dat_i, wmask, aer_error_log_pkg::UNC_BITS);
      end
      if (wr_en && wb_adr_i == aer_error_log_pkg::UNC_SEV_OFF) begin
        unc_sev_q <= rw(unc_sev_q, wb_dat_i, wmask, aer_error_log_pkg::UNC_BITS);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cor_status_q <= 32'h00000000;
      cor_mask_q <= 32'h00000000;
    end else begin
      cor_status_q <= w1c(cor_status_q, cor_err_i & aer_error_log_pkg::COR_BITS,
        (wr_en && wb_adr_i == aer_error_log_pkg::COR_STATUS_OFF) ? wb_dat_i & wmask
        : 32'h00000000, aer_error_log_pkg::COR_BITS);
      if (wr_en && wb_adr_i == aer_error_log_pkg::COR_MASK_OFF) begin
        cor_mask_q <= rw(cor_mask_q, wb_dat_i, wmask, aer_error_log_pkg::COR_BITS);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_status_q <= 32'h00000000;
      sec_mask_q <= aer_error_log_pkg::SEC_MASK_RESET;
      sec_sev_q <= aer_error_log_pkg::SEC_SEV_RESET;
    end else begin
      sec_status_q <= w1c(sec_status_q, sec_err_i & aer_error_log_pkg::SEC_BITS,
        (wr_en && wb_adr_i == aer_error_log_pkg::SEC_STATUS_OFF) ? wb_dat_i & wmask
        : 32'h00000000, aer_error_log_pkg::SEC_BITS);
      if (wr_en && wb_adr_i == aer_error_log_pkg::SEC_MASK_OFF) begin
        sec_mask_q <= rw(sec_mask_q, wb_dat_i, wmask, aer_error_log_pkg::SEC_BITS);
      end
      if (wr_en && wb_adr_i == aer_error_log_pkg::SEC_SEV_OFF) begin
        sec_sev_q <= rw(sec_sev_q, wb_dat_i, wmask, aer_error_log_pkg::SEC_BITS);
      end
    end
  end

  // ECRC enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_en_q <= 1'b0;
      chk_en_q <= 1'b0;
    end else if (wr_en && wb_adr_i == aer_error_log_pkg::CAP_CTRL_OFF && wb_sel_i[1:0] != 2'h0) begin
      if (wb_sel_i[0]) begin
        gen_en_q <= wb_dat_i[aer_error_log_pkg::ECRC_GEN_EN_BIT];
      end
      if (wb_sel_i[1]) begin
        chk_en_q <= wb_dat_i[aer_error_log_pkg::ECRC_CHK_EN_BIT];
      end
    end
  end

  // Pointer and header capture on unmasked uncorrectable error
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fep_q <= 5'h00;
      for (int i = 0; i < 4; i++) begin
        hdr_q[i] <= 32'h00000000;
      end
    end else if (log_unc) begin
      fep_q <= fep_idx;
      for (int i = 0; i < 4; i++) begin
        hdr_q[i] <= err_header_i[127 - 32 * i -: 32];
      end
    end
  end

  // Interrupt status, mask and output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_q <= 3'h0;
      irq_mask_q <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~((wr_en && wb_adr_i == aer_error_log_pkg::IRQ_STATUS_OFF
        && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0)) | irq_ev;
      if (wr_en && wb_adr_i == aer_error_log_pkg::IRQ_MASK_OFF && wb_sel_i[0]) begin
        irq_mask_q <= wb_dat_i[2:0] & aer_error_log_pkg::IRQ_BITS;
      end
      irq_o <= |(irq_status_q & irq_mask_q);
    end
  end

  // Error message pulses
  always_ff @(posedge clk_i) begin
    if (rst_i || link_reset_i) begin
      err_fatal_o <= 1'b0;
      err_nonfatal_o <= 1'b0;
      err_cor_o <= 1'b0;
    end else begin
      err_fatal_o <= fatal_ev;
      err_nonfatal_o <= nonfatal_ev;
      err_cor_o <= cor_ev;
    end
  end

  always_comb begin
    rdata = 32'h00000000;
    unique case (wb_adr_i)
      aer_error_log_pkg::UNC_STATUS_OFF: rdata = unc_status_q;
      aer_error_log_pkg::UNC_MASK_OFF: rdata = unc_mask_q;
      aer_error_log_pkg::UNC_SEV_OFF: rdata = unc_sev_q;
      aer_error_log_pkg::COR_STATUS_OFF: rdata = cor_status_q;
      aer_error_log_pkg::COR_MASK_OFF: rdata = cor_mask_q;
      aer_error_log_pkg::CAP_CTRL_OFF: begin
        rdata[4:0] = fep_q;
        rdata[aer_error_log_pkg::ECRC_GEN_CAP_BIT] = 1'b1;
        rdata[aer_error_log_pkg::ECRC_GEN_EN_BIT] = gen_en_q;
        rdata[aer_error_log_pkg::ECRC_CHK_CAP_BIT] = 1'b1;
        rdata[aer_error_log_pkg::ECRC_CHK_EN_BIT] = chk_en_q;
      end
      aer_error_log_pkg::HDR_LOG0_OFF: rdata = hdr_q[0];
      aer_error_log_pkg::HDR_LOG1_OFF: rdata = hdr_q[1];
      aer_error_log_pkg::HDR_LOG2_OFF: rdata = hdr_q[2];
      aer_error_log_pkg::HDR_LOG3_OFF: rdata = hdr_q[3];
      aer_error_log_pkg::SEC_STATUS_OFF: rdata = sec_status_q;
      aer_error_log_pkg::SEC_MASK_OFF: rdata = sec_mask_q;
      aer_error_log_pkg::SEC_SEV_OFF: rdata = sec_sev_q;
      aer_error_log_pkg::IRQ_STATUS_OFF: rdata = {29'h0, irq_status_q};
      aer_error_log_pkg::IRQ_MASK_OFF: rdata = {29'h0, irq_mask_q};
      default: rdata = 32'h00000000;
    endcase
  end

  // Bus answer one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rdata : 32'h00000000;
    end
  end

  assign ecrc_gen_en_o = gen_en_q;
  assign ecrc_chk_en_o = chk_en_q;
endmodule

`default_nettype wire

// *** tb/aer_error_log_checker.sv ***
// Bus timing and field checks for the error log register bank
`timescale 1ns/1ps
`default_nettype none
module aer_error_log_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [31:0] unc_err_i,
  input wire logic [31:0] cor_err_i,
  input wire logic [31:0] sec_err_i,
  input wire logic err_fatal_o,
  input wire logic err_cor_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_rd(a); wb_ack_o && !wb_we_i && wb_adr_i == a; endsequence
  property p_ack_lat; s_req |=> s_ack; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack not a single cycle later");
  property p_no_req; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_no_req: assert property (p_no_req) else $error("ack without request");
  property p_idle_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside ack");
  property p_sev_rsv; s_rd(12'h10C) |-> wb_dat_o[31:21] == 11'h0; endproperty
  a_sev_rsv: assert property (p_sev_rsv) else $error("severity reserved bits set");
  property p_cor_rsv; s_rd(12'h110) |-> (wb_dat_o & ~32'h000011C1) == 32'h0; endproperty
  a_cor_rsv: assert property (p_cor_rsv) else $error("correctable reserved bits set");
  property p_cap; s_rd(12'h118) |-> wb_dat_o[5] && wb_dat_o[7] && wb_dat_o[31:9] == 23'h0;
  endproperty
  a_cap: assert property (p_cap) else $error("capability bits wrong");
  property p_sec_rsv; s_rd(12'h12C) |-> !wb_dat_o[4] && wb_dat_o[31:14] == 18'h0; endproperty
  a_sec_rsv: assert property (p_sec_rsv) else $error("secondary reserved bits set");
  property p_cor_cause; err_cor_o |-> $past(cor_err_i) != 32'h0; endproperty
  a_cor_cause: assert property (p_cor_cause) else $error("correctable report uncaused");
  property p_fat_cause; err_fatal_o |-> ($past(unc_err_i) | $past(sec_err_i)) != 32'h0;
  endproperty
  a_fat_cause: assert property (p_fat_cause) else $error("fatal report uncaused");
endmodule
bind aer_error_log_regs aer_error_log_checker u_chk (.*);
`default_nettype wire

// *** tb/cfg_host.sv ***
// Configuration request master standing in for the host side
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_rdat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [11:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_wdat_o
);
  logic hung = 1'b0;
  initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_wdat_o} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'hF;
    wb_wdat_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 50);
    if (n >= 50) hung = 1'b1;
    q = wb_rdat_i;
    // Released address and data lines show no stale value
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~a;
    wb_wdat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// *** tb/aer_error_log_regs_test.sv ***
// Testbench for the error log register bank
`timescale 1ns/1ps
`default_nettype none
module aer_error_log_regs_test;
  localparam logic [127:0] HDR = 128'h00112233_44556677_8899AABB_CCDDEEFF;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_reset_i = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ecrc_gen_en_o, ecrc_chk_en_o;
  logic err_fatal_o, err_nonfatal_o, err_cor_o, irq_o;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, unc_err_i = '0, cor_err_i = '0, sec_err_i = '0;
  logic [127:0] err_header_i = '0;
  int failures = 0;
  int comparisons = 0;
  aer_error_log_regs DUT (.*);
  cfg_host host (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_rdat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
    .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
    .wb_wdat_o(wb_dat_i));
  initial forever #20 clk_i = ~clk_i;
  task automatic end_of_test;
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  // Error pulses are checked at the edge after the detect pulse is taken
  task automatic ev(input logic [31:0] u, input logic [31:0] c, input logic [31:0] s,
                    input logic [2:0] p);
    @(posedge clk_i);
    {unc_err_i, cor_err_i, sec_err_i} <= {u, c, s};
    @(posedge clk_i);
    {unc_err_i, cor_err_i, sec_err_i} <= '0;
    @(posedge clk_i);
    chk({29'h0, err_fatal_o, err_nonfatal_o, err_cor_o}, {29'h0, p});
  endtask
  task automatic t_reset_values;
    logic [11:0] a[7] = '{12'h10C, 12'h118, 12'h130, 12'h134, 12'h104, 12'h108, 12'h300};
    logic [31:0] e[7] = '{32'h00062011, 32'h000000A0, 32'h000017A8, 32'h00001340, 32'h0,
                          32'h0, 32'h0};
    logic [11:0] z[7] = '{12'h110, 12'h114, 12'h11C, 12'h120, 12'h124, 12'h128, 12'h12C};
    foreach (a[i]) rc(a[i], e[i]);
    foreach (z[i]) rc(z[i], 32'h0);
  endtask
  task automatic t_rw;
    logic [11:0] a[6] = '{12'h10C, 12'h114, 12'h118, 12'h130, 12'h134, 12'h300};
    logic [31:0] e[6] = '{32'h001FF011, 32'h000011C1, 32'h000001E0, 32'h00003FEF,
                          32'h00003FEF, 32'h0};
    foreach (a[i]) wr(a[i], 32'hFFFFFFFF);
    foreach (a[i]) rc(a[i], e[i]);
    chk({30'h0, ecrc_gen_en_o, ecrc_chk_en_o}, 32'h3);
    foreach (a[i]) wr(a[i], i == 0 ? 32'h00062011 : 32'h0);
  endtask
  task automatic t_cor_irq;
    ev(32'h0, 32'hFFFFFFFF, 32'h0, 3'h1);
    rc(12'h110, 32'h000011C1);
    wr(12'h110, 32'h00000041);
    rc(12'h110, 32'h00001180);
    chk({31'h0, irq_o}, 32'h0);
    wr(12'h204, 32'h00000001);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(12'h200, 32'h00000001);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task automatic t_unc;
    err_header_i <= HDR;
    ev(32'h00002000, 32'h0, 32'h0, 3'h4);
    err_header_i <= ~HDR;
    rc(12'h104, 32'h00002000);
    rc(12'h118, 32'h000000AD);
    wr(12'h108, 32'h00000010);
    ev(32'h00000010, 32'h0, 32'h0, 3'h0);
    rc(12'h104, 32'h00002010);
    rc(12'h118, 32'h000000AD);
    for (int i = 0; i < 4; i++) rc(12'h11C + 12'(4 * i), HDR[127 - 32 * i -: 32]);
  endtask
  task automatic t_sec_sticky;
    ev(32'h0, 32'h0, 32'hFFFFFFFF, 3'h2);
    rc(12'h12C, 32'h00003FEF);
    wr(12'h12C, 32'hFFFFFFFF);
    rc(12'h12C, 32'h0);
    @(posedge clk_i);
    link_reset_i <= 1'b1;
    @(posedge clk_i);
    link_reset_i <= 1'b0;
    rc(12'h104, 32'h00002010);
    rc(12'h118, 32'h000000AD);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(12'h104, 32'h0);
    rc(12'h10C, 32'h00062011);
  endtask
  initial begin
    wait (host.hung);
    failures++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values;
    t_rw;
    t_cor_irq;
    t_unc;
    t_sec_sticky;
    end_of_test;
  end
endmodule
`default_nettype wire
